// file: hw/att_regs.sv
// Purpose: alarm, countdown and temperature registers behind the serial register port
// Assumes: register port and watch counters run on clk; no crossing needed
// Notes: unused bits are dropped on write and so read as zero
`timescale 1ns/1ns
`default_nettype none
`include "att_defs.svh"
module att_regs (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  input  wire logic                reg_access,
  output logic [7:0]               reg_rdata,
  input  wire att_pkg::att_cal_t   now,
  input  wire logic                minsec_match,
  input  wire logic                minsec_enabled,
  input  wire logic                alarm_irq_enable,
  input  wire logic                alarm_flag_clear,
  output logic                     alarm_flag,
  output logic                     int_n,
  output logic [15:0]              countdown_value,
  input  wire logic                therm_enable,
  input  wire logic [7:0]          temp_measured,
  input  wire logic                temp_valid,
  output logic [7:0]               temperature_value,
  output logic signed [8:0]        temperature_celsius
);
  att_pkg::att_cal_t alarm;
  logic [7:0]        countdown_low_byte;
  logic [7:0]        countdown_high_byte;
  logic [7:0]        temp_cache;
  logic              match_seen;
  att_cmp_if         cmp_bus ();

  function automatic logic [7:0] write_mask(input logic [7:0] addr);
    case (addr)
      `ATT_OFF_HOURS:   write_mask = `ATT_MASK_HOURS;
      `ATT_OFF_DAYS:    write_mask = `ATT_MASK_DAYS;
      `ATT_OFF_WEEKDAY: write_mask = `ATT_MASK_WEEKDAY;
      `ATT_OFF_MONTH:   write_mask = `ATT_MASK_MONTH;
      `ATT_OFF_YEAR:    write_mask = `ATT_MASK_YEAR;
      default:          write_mask = 8'hFF;
    endcase
  endfunction : write_mask

  wire logic [7:0] masked_wdata = reg_wdata & write_mask(reg_addr);
  wire logic       wr_hours     = reg_write && reg_addr == `ATT_OFF_HOURS;
  wire logic       wr_days      = reg_write && reg_addr == `ATT_OFF_DAYS;
  wire logic       wr_weekday   = reg_write && reg_addr == `ATT_OFF_WEEKDAY;
  wire logic       wr_month     = reg_write && reg_addr == `ATT_OFF_MONTH;
  wire logic       wr_year      = reg_write && reg_addr == `ATT_OFF_YEAR;
  wire logic       wr_cnt_low   = reg_write && reg_addr == `ATT_OFF_CNT_LOW;
  wire logic       wr_cnt_high  = reg_write && reg_addr == `ATT_OFF_CNT_HIGH;
  wire logic       wr_temp      = reg_write && reg_addr == `ATT_OFF_TEMP &&
                                  !therm_enable;
  // measured codes above the top of the scale are held at the top
  wire logic [7:0] temp_clamped = (temp_measured > `ATT_TEMP_MAX) ?
                                  `ATT_TEMP_MAX : temp_measured;
  wire logic       meas_load    = temp_valid && therm_enable;

  logic [7:0] next_rdata;
  always_comb
  begin
    case (reg_addr)
      `ATT_OFF_HOURS:    next_rdata = alarm.hours;
      `ATT_OFF_DAYS:     next_rdata = alarm.days;
      `ATT_OFF_WEEKDAY:  next_rdata = alarm.weekday;
      `ATT_OFF_MONTH:    next_rdata = alarm.month;
      `ATT_OFF_YEAR:     next_rdata = alarm.year;
      `ATT_OFF_CNT_LOW:  next_rdata = countdown_low_byte;
      `ATT_OFF_CNT_HIGH: next_rdata = countdown_high_byte;
      `ATT_OFF_TEMP:     next_rdata = temp_cache;
      default:           next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      alarm <= '0;
    end
    else
    begin
      if (wr_hours)
        alarm.hours <= masked_wdata;
      if (wr_days)
        alarm.days <= masked_wdata;
      if (wr_weekday)
        alarm.weekday <= masked_wdata;
      if (wr_month)
        alarm.month <= masked_wdata;
      if (wr_year)
        alarm.year <= masked_wdata;
    end
  end

  // no range check on the low byte: a zero written by the host is kept as is
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      countdown_low_byte  <= `ATT_RESET_VALUE;
      countdown_high_byte <= `ATT_RESET_VALUE;
    end
    else
    begin
      if (wr_cnt_low)
        countdown_low_byte <= reg_wdata;
      if (wr_cnt_high)
        countdown_high_byte <= reg_wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      countdown_value <= 16'h0000;
    else if (wr_cnt_low)
      countdown_value <= {countdown_high_byte, reg_wdata};
    else if (wr_cnt_high)
      countdown_value <= {reg_wdata, countdown_low_byte};
  end

  // live result keeps updating; only the copy seen by the host is frozen
  always_ff @(posedge clk)
  begin
    if (reset)
      temperature_value <= `ATT_RESET_VALUE;
    else if (meas_load)
      temperature_value <= temp_clamped;
    else if (wr_temp)
      temperature_value <= reg_wdata;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      temp_cache <= `ATT_RESET_VALUE;
    else if (!reg_access)
      temp_cache <= temperature_value;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      temperature_celsius <= 9'sh000;
    else
      temperature_celsius <= $signed({1'b0, temperature_value}) -
                             $signed({1'b0, `ATT_TEMP_ZERO_C});
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (reg_read)
      reg_rdata <= next_rdata;
  end

  assign cmp_bus.alarm = alarm;
  assign cmp_bus.now   = now;

  att_alarm_cmp u_cmp (
    .clk   (clk),
    .reset (reset),
    .cmp   (cmp_bus.cmp)
  );

  // with no field enabled anywhere there is nothing to match
  wire logic full_match = cmp_bus.match && minsec_match &&
                          (cmp_bus.any_enabled || minsec_enabled);
  wire logic match_rise = full_match && !match_seen;
  wire logic flag_set   = match_rise && alarm_irq_enable;
  wire logic next_flag  = flag_set || (alarm_flag && !alarm_flag_clear);   // set beats clear

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      match_seen <= 1'b0;
      alarm_flag <= 1'b0;
      int_n      <= 1'b1;
    end
    else
    begin
      match_seen <= full_match;
      alarm_flag <= next_flag;
      int_n      <= !next_flag;
    end
  end
endmodule : att_regs
`default_nettype wire

// file: hw/att_defs.svh
// Purpose: offsets, field positions, masks and codes of the alarm, timer and temperature pages
// Assumes: byte-wide registers at their printed addresses
// Notes: reset values are not given for these registers; zero is used throughout
// Operation
// - hours-alarm bit 7 enables hour comparison; 0 disables it
// - hour alarm BCD 1-12 plus pm bit 5, or BCD 0-23; bit 6 unused
// - days alarm: enable bit 7, bit 6 unused, BCD day 1-31 in 5:0
// - weekday alarm: enable bit 7, bits 6:3 unused, weekday 1-7 in 2:0
// - months alarm: enable bit 7, bits 6:5 unused, BCD month 1-12 in 4:0
// - years alarm: enable bit 7, BCD year 0-79 in 6:0
// - countdown value is 16 bits: low byte at 18h, high byte at 19h
// - countdown high byte stored in binary, any value 0 to 255
// - temperature code 0..250 means -60 to +190 degrees, one-degree steps
// - code 60 means zero degrees; code minus 60 gives degrees
// - temperature frozen in a cached copy during any host access
// - host may write temperature only while thermometer is disabled
// - first match of all enabled fields with irq enable sets flag, int low
// - fields with enable bit 0 are left out of the match
`ifndef ATT_DEFS_SVH
`define ATT_DEFS_SVH

`define ATT_OFF_HOURS     8'h12
`define ATT_OFF_DAYS      8'h13
`define ATT_OFF_WEEKDAY   8'h14
`define ATT_OFF_MONTH     8'h15
`define ATT_OFF_YEAR      8'h16
`define ATT_OFF_CNT_LOW   8'h18
`define ATT_OFF_CNT_HIGH  8'h19
`define ATT_OFF_TEMP      8'h20

`define ATT_ENABLE_BIT    7
`define ATT_PM_BIT        5

`define ATT_MASK_HOURS    8'hBF
`define ATT_MASK_DAYS     8'hBF
`define ATT_MASK_WEEKDAY  8'h87
`define ATT_MASK_MONTH    8'h9F
`define ATT_MASK_YEAR     8'hFF
`define ATT_MASK_FIELD    8'h7F

`define ATT_RESET_VALUE   8'h00
`define ATT_TEMP_MAX      8'hFA
`define ATT_TEMP_ZERO_C   8'h3C

`endif

// file: hw/att_pkg.sv
// Purpose: shared types of the alarm, timer and temperature register block
// Assumes: byte-wide registers
// Notes: calendar fields are BCD as held in the watch page
package att_pkg;

  typedef logic [7:0] att_byte_t;

  typedef struct packed {
    att_byte_t hours;
    att_byte_t days;
    att_byte_t weekday;
    att_byte_t month;
    att_byte_t year;
  } att_cal_t;

endpackage : att_pkg

// file: hw/att_cmp_if.sv
// Purpose: carries alarm settings and current calendar to the comparator
// Assumes: one clock domain
// Notes: match is registered in the comparator
`timescale 1ns/1ns
`default_nettype none
interface att_cmp_if;
  att_pkg::att_cal_t alarm;
  att_pkg::att_cal_t now;
  logic              any_enabled;
  logic              match;

  modport regs (output alarm, output now, input any_enabled, input match);
  modport cmp  (input alarm, input now, output any_enabled, output match);
endinterface : att_cmp_if
`default_nettype wire

// file: hw/att_alarm_cmp.sv
// Purpose: compares enabled alarm fields with the current calendar
// Assumes: calendar inputs already in the clock domain
// Notes: one cycle of latency on match
`timescale 1ns/1ns
`default_nettype none
`include "att_defs.svh"
module att_alarm_cmp (
  input  wire logic clk,
  input  wire logic reset,
  att_cmp_if.cmp    cmp
);
  logic [4:0] enables;
  logic [4:0] field_ok;
  logic [7:0] alarm_bytes [5];
  logic [7:0] now_bytes   [5];

  assign alarm_bytes[0] = cmp.alarm.hours;
  assign alarm_bytes[1] = cmp.alarm.days;
  assign alarm_bytes[2] = cmp.alarm.weekday;
  assign alarm_bytes[3] = cmp.alarm.month;
  assign alarm_bytes[4] = cmp.alarm.year;
  assign now_bytes[0]   = cmp.now.hours;
  assign now_bytes[1]   = cmp.now.days;
  assign now_bytes[2]   = cmp.now.weekday;
  assign now_bytes[3]   = cmp.now.month;
  assign now_bytes[4]   = cmp.now.year;

  genvar i;
  generate
    for (i = 0; i < 5; i++)
    begin : g_field
      assign enables[i]  = alarm_bytes[i][`ATT_ENABLE_BIT];
      // pm bit takes part in hour compare, so 12h and 24h both compare 6:0
      assign field_ok[i] = !enables[i] ||
                           ((alarm_bytes[i] & `ATT_MASK_FIELD) ==
                            (now_bytes[i] & `ATT_MASK_FIELD));
    end
  endgenerate

  assign cmp.any_enabled = |enables;

  always_ff @(posedge clk)
  begin
    if (reset)
      cmp.match <= 1'b0;
    else
      cmp.match <= &field_ok;
  end
endmodule : att_alarm_cmp
`default_nettype wire

// file: bench/att_regs_asserts.sv
// Purpose: port checks of att_regs
// Assumes: one clock, synchronous reset
// Notes: the bind sits at the foot
`timescale 1ns/1ns
`default_nettype none
module att_regs_asserts (
  input wire logic               clk,
  input wire logic               reset,
  input wire logic [7:0]         reg_addr,
  input wire logic [7:0]         reg_wdata,
  input wire logic               reg_write,
  input wire logic               alarm_irq_enable,
  input wire logic               alarm_flag_clear,
  input wire logic               alarm_flag,
  input wire logic               int_n,
  input wire logic [15:0]        countdown_value,
  input wire logic               therm_enable,
  input wire logic               temp_valid,
  input wire logic [7:0]         temperature_value,
  input wire logic signed [8:0]  temperature_celsius
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_INT: assert property (int_n == !alarm_flag)
    else $error("int_n is not the inverse of the flag");
  AST_LOW: assert property (reg_write && reg_addr == 8'h18
    |=> countdown_value[7:0] == $past(reg_wdata)) else $error("low byte lost");
  AST_HIGH: assert property (reg_write && reg_addr == 8'h19
    |=> countdown_value[15:8] == $past(reg_wdata)) else $error("high byte lost");
  // celsius lags one cycle, so skip the first edge out of reset
  AST_CEL: assert property (!$past(reset) |-> temperature_celsius ==
    $signed({1'b0, $past(temperature_value)}) - 9'sd60) else $error("celsius wrong");
  AST_TMAX: assert property (temperature_value <= 8'hFA)
    else $error("temperature above top code");
  AST_TLOCK: assert property (reg_write && reg_addr == 8'h20 && therm_enable
    && !temp_valid |=> $stable(temperature_value)) else $error("write while measuring");
  AST_SET: assert property ($rose(alarm_flag) |-> $past(alarm_irq_enable))
    else $error("flag set while irq disabled");
  AST_STICKY: assert property (alarm_flag && !alarm_flag_clear |=> alarm_flag)
    else $error("flag dropped without clear");
endmodule : att_regs_asserts
bind att_regs att_regs_asserts i_chk (.clk, .reset, .reg_addr, .reg_wdata, .reg_write,
  .alarm_irq_enable, .alarm_flag_clear, .alarm_flag, .int_n, .countdown_value,
  .therm_enable, .temp_valid, .temperature_value, .temperature_celsius);
`default_nettype wire

// file: bench/att_host.sv
// Purpose: host side of the register port
// Assumes: drives on the falling edge
// Notes: released data is inverted so stale bytes never pass
`timescale 1ns/1ns
`default_nettype none
module att_host (
  input  wire logic  clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic       reg_write,
  output logic       reg_read,
  output logic       reg_access
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_access = 1'b0;
  end
  // callers never hand a zero low countdown byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    q = tb.reg_rdata;
  endtask : rd
  task automatic hold(input logic on);
    @(negedge clk);
    reg_access = on;
  endtask : hold
endmodule : att_host
`default_nettype wire

// file: bench/tb.sv
// Purpose: self-checking bench of att_regs
// Assumes: host model drives the register port
// Notes: inputs change on the falling edge
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk, reset, reg_write, reg_read, reg_access, minsec_match, minsec_enabled;
  logic alarm_irq_enable, alarm_flag_clear, alarm_flag, int_n, therm_enable, temp_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, temp_measured, temperature_value, q;
  logic [15:0] countdown_value;
  logic signed [8:0] temperature_celsius;
  att_pkg::att_cal_t now;
  int mismatches, checks;
  att_regs i_att_regs (.clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_access, .reg_rdata, .now, .minsec_match, .minsec_enabled, .alarm_irq_enable,
    .alarm_flag_clear, .alarm_flag, .int_n, .countdown_value, .therm_enable,
    .temp_measured, .temp_valid, .temperature_value, .temperature_celsius);
  att_host i_att_host (.clk, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_access);
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic t_regs;
    logic [7:0] ad [8] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h18, 8'h19, 8'h17};
    logic [7:0] mk [8] = '{8'hBF, 8'hBF, 8'h87, 8'h9F, 8'hFF, 8'hFF, 8'hFF, 8'h00};
    foreach (ad[i]) i_att_host.wr(ad[i], 8'hFF);
    foreach (ad[i])
    begin
      i_att_host.rd(ad[i], q);
      check("readback", {8'h00, q}, {8'h00, mk[i]});
    end
    i_att_host.wr(8'h18, 8'h01);
    i_att_host.wr(8'h19, 8'h00);
    check("countdown", countdown_value, 16'h0001);
  endtask : t_regs
  task automatic meas(input logic [7:0] c);
    @(negedge clk);
    temp_measured = c;
    temp_valid = 1'b1;
    @(negedge clk);
    temp_valid = 1'b0;
    temp_measured = ~c;
    @(negedge clk);
  endtask : meas
  task automatic t_temp;
    i_att_host.wr(8'h20, 8'h3C);
    @(negedge clk);
    check("temp write", {8'h00, temperature_value}, 16'h003C);
    check("celsius zero", {7'h00, temperature_celsius}, 16'h0000);
    therm_enable = 1'b1;
    i_att_host.wr(8'h20, 8'h11);
    check("temp locked", {8'h00, temperature_value}, 16'h003C);
    meas(8'hFF);
    check("temp clamp", {8'h00, temperature_value}, 16'h00FA);
    check("celsius top", {7'h00, temperature_celsius}, 16'h00BE);
    meas(8'h00);
    check("celsius low", {7'h00, temperature_celsius}, 16'h01C4);
  endtask : t_temp
  task automatic t_cache;
    i_att_host.hold(1'b1);
    meas(8'h50);
    i_att_host.rd(8'h20, q);
    check("cached temp", {8'h00, q}, 16'h0000);
    i_att_host.hold(1'b0);
    i_att_host.rd(8'h20, q);
    check("fresh temp", {8'h00, q}, 16'h0050);
  endtask : t_cache
  task automatic t_alarm;
    i_att_host.wr(8'h12, 8'hA7);
    i_att_host.wr(8'h13, 8'h15);
    for (int a = 8'h14; a < 8'h17; a++) i_att_host.wr(8'(a), 8'h00);
    now.hours = 8'h07;
    minsec_match = 1'b1;
    alarm_irq_enable = 1'b1;
    repeat (4) @(negedge clk);
    check("am vs pm", {15'h0000, alarm_flag}, 16'h0000);
    now.hours = 8'h27;
    repeat (3) @(negedge clk);
    check("flag", {15'h0000, alarm_flag}, 16'h0001);
    check("int", {15'h0000, int_n}, 16'h0000);
    alarm_flag_clear = 1'b1;
    @(negedge clk);
    alarm_flag_clear = 1'b0;
    repeat (3) @(negedge clk);
    check("no reset", {15'h0000, alarm_flag}, 16'h0000);
    alarm_irq_enable = 1'b0;
    now.hours = 8'h07;
    repeat (3) @(negedge clk);
    now.hours = 8'h27;
    repeat (3) @(negedge clk);
    check("irq off", {15'h0000, alarm_flag}, 16'h0000);
    alarm_irq_enable = 1'b1;
    i_att_host.wr(8'h12, 8'h27);
    @(negedge clk);
    minsec_enabled = 1'b1;
    repeat (3) @(negedge clk);
    check("minsec only", {15'h0000, alarm_flag}, 16'h0001);
  endtask : t_alarm
  task automatic t_reset;
    minsec_match = 1'b0;
    minsec_enabled = 1'b0;
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    check("flag after reset", {15'h0000, alarm_flag}, 16'h0000);
    check("int after reset", {15'h0000, int_n}, 16'h0001);
    check("countdown after reset", countdown_value, 16'h0000);
    i_att_host.rd(8'h12, q);
    check("hours after reset", {8'h00, q}, 16'h0000);
  endtask : t_reset
  initial
  begin
    reset = 1'b1;
    now = '0;
    {minsec_match, minsec_enabled, alarm_irq_enable, alarm_flag_clear} = 4'h0;
    {therm_enable, temp_valid, temp_measured} = 10'h000;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    t_regs;
    t_temp;
    t_cache;
    t_alarm;
    t_reset;
    print_verdict;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    mismatches++;
    print_verdict;
  end
endmodule : tb
`default_nettype wire
